// ==== tpc_top.sv ====
// Teletext page wipe, packet flags and data-service capture
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Link packet 27 designation 0 sets link flag; software writes 0 to clear.
// - On low-rate system only X/0/27/0 (tab bit zero) sets link flag.
// - Packet 8/30, or 4/30 on low-rate, sets service flag; write 0 clears. Code sets it on 8/30 only, on either system.
// - First header after request, or header with erase bit, starts a wipe.
// - Hardware wipe spaces rows 1-23, extension row 1 and packet-24 row.
// - Packet-24 row is basic row 24 if placement bit set, else extension 0.
// - Header-triggered wipe completes within the header's TV line.
// - Software wipe request clears all memory; bit self-clears.
// - One wipe per line; pending software wipe runs on next free line.
// - Wipe-in-progress flag set on software request, cleared when done.
// - Reset wipes whole memory and shows wipe-in-progress until done.
// - All-lines bit accepts packets on any line, not just blanking.
// - Data-service enable makes device capture packets 30 and 31.
// - Sixteen channels from magazine and packet LSB; channel 0 is 8/30.
// - Only packets matching software-selected channel are captured.
// - Captured packets fill rows 0-23 in turn, wrapping after 24.
// - No hardware wipe in data-service mode; software wipe resets row counter.
// - Data-service bytes are stored without error checking.
// - Capture identical for low-rate and high-rate systems.
// - Low-rate flag reflects detection and selects flag packet variants. Code uses it for the link flag only.
module tpc_top #(
  parameter int COLS = tpc_pkg::TPC_COLS
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Avalon-MM slave
  input  wire logic [3:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // Packet recogniser
  input  wire logic             pkt_valid_i,
  input  wire tpc_pkg::tpc_pkt_t pkt_i,
  input  wire logic [7:0]       pkt_byte_i,
  input  wire logic [5:0]       pkt_col_i,
  input  wire logic             pkt_byte_valid_i,
  input  wire logic             line_start_i,
  input  wire logic             vbi_i,
  input  wire logic             low_rate_det_i,
  // Page memory write port
  output tpc_pkg::tpc_mem_wr_t  mem_wr_o,
  // Status
  output logic                  accept_line_o,
  output logic                  ds_capture_o
);
  import tpc_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------------------
  // Internal logic leaves reset two edges after the pin is released
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Control and flag state
  // ---------------------------------------------------------------------------
  logic       ext_row_placement_bit_r;
  logic       all_lines_acquire_bit_r;
  logic       data_service_enable_bit_r;
  logic [3:0] ds_channel_r;
  logic       link_packet_seen_flag_r;
  logic       service_packet_seen_flag_r;
  logic       wipe_in_progress_flag_r;
  logic       soft_pending_r;
  logic       low_rate_system_flag_r;
  logic [4:0] ds_row_r;
  logic [4:0] ds_row_nxt;

  tpc_state_t     state_r;
  tpc_wipe_kind_t kind_r;
  logic [4:0]     wrow_r;
  logic [5:0]     wcol_r;
  logic           wext_r;
  logic           line_used_r;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_chan;
  logic pkt_ok;
  logic link_hit;
  logic svc_hit;
  logic hard_req;
  logic ds_hit;
  logic soft_wr;
  logic wipe_done;
  logic [3:0] pkt_chan;

  assign wr_ctrl = avs_write_i && (avs_address_i == TPC_ADDR_CTRL)
                   && avs_byteenable_i[0];
  assign wr_stat = avs_write_i && (avs_address_i == TPC_ADDR_STATUS)
                   && avs_byteenable_i[0];
  assign wr_chan = avs_write_i && (avs_address_i == TPC_ADDR_CHAN)
                   && avs_byteenable_i[0];
  assign soft_wr = wr_ctrl && avs_writedata_i[TPC_CTRL_WIPE_REQ];

  // ---------------------------------------------------------------------------
  // Packet classification
  // ---------------------------------------------------------------------------
  assign accept_line_o = all_lines_acquire_bit_r || vbi_i;
  assign pkt_ok = pkt_valid_i && accept_line_o;
  // Link packet seen whether or not acquired
  assign link_hit = pkt_valid_i && (pkt_i.pkt == TPC_PKT_LINK)
                    && (pkt_i.desig == TPC_DESIG_ZERO)
                    && !(low_rate_system_flag_r && pkt_i.tab);
  // Magazine 8 encodes as zero magazine bits; magazine 4 is not matched
  assign svc_hit = pkt_valid_i && (pkt_i.pkt == TPC_PKT_SVC)
                   && (pkt_i.mag == TPC_MAG_SVC_HI);
  assign pkt_chan = {pkt_i.mag, pkt_i.pkt[0]};
  // Same path regardless of line system, no error checks
  assign ds_hit = pkt_ok && data_service_enable_bit_r
                  && (pkt_i.pkt[4:1] == TPC_PKT_DS_LO[4:1])
                  && (pkt_chan == ds_channel_r);
  // Headers only force a wipe outside data-service mode
  assign hard_req = pkt_ok && pkt_i.header && !data_service_enable_bit_r
                    && (pkt_i.first_hdr || pkt_i.erase);

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // The wipe request bit is not stored; it only raises soft_wr for one cycle
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_row_placement_bit_r   <= 1'b0;
      all_lines_acquire_bit_r   <= 1'b0;
      data_service_enable_bit_r <= 1'b0;
      ds_channel_r              <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ext_row_placement_bit_r   <= avs_writedata_i[TPC_CTRL_EXT_POS];
        all_lines_acquire_bit_r   <= avs_writedata_i[TPC_CTRL_ALL_LINES];
        data_service_enable_bit_r <= avs_writedata_i[TPC_CTRL_DS_EN];
      end
      if (wr_chan) begin
        ds_channel_r <= avs_writedata_i[3:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Seen flags: set wins over clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      link_packet_seen_flag_r    <= 1'b0;
      service_packet_seen_flag_r <= 1'b0;
      low_rate_system_flag_r     <= 1'b0;
    end else begin
      // The low-rate flag follows the detector one clock late
      low_rate_system_flag_r <= low_rate_det_i;
      if (link_hit) begin
        link_packet_seen_flag_r <= 1'b1;
      end else if (wr_stat && !avs_writedata_i[TPC_STAT_LINK]) begin
        link_packet_seen_flag_r <= 1'b0;
      end
      if (svc_hit) begin
        service_packet_seen_flag_r <= 1'b1;
      end else if (wr_stat && !avs_writedata_i[TPC_STAT_SERVICE]) begin
        service_packet_seen_flag_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Wipe engine: one location per clock
  // ---------------------------------------------------------------------------
  // Software and reset wipes end on the last extension row, hardware wipes
  // on extension row 1, which they reach after the packet-24 row
  assign wipe_done = (state_r == TPC_WIPE) && (wcol_r == TPC_COL_LAST)
                     && wext_r
                     && (kind_r == TPC_SOFT
                         ? (wrow_r == 5'(TPC_ROWS - 1))
                         : (wrow_r == TPC_ROW_FIRST));

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r         <= TPC_WIPE;
      kind_r          <= TPC_SOFT;
      wrow_r          <= 5'h00;
      wcol_r          <= 6'h00;
      wext_r          <= 1'b0;
      line_used_r     <= 1'b1;
      soft_pending_r  <= 1'b0;
      wipe_in_progress_flag_r <= 1'b1;
    end else begin
      if (soft_wr) begin
        soft_pending_r          <= 1'b1;
        wipe_in_progress_flag_r <= 1'b1;
      end
      if (line_start_i) begin
        line_used_r <= 1'b0;
      end
      // A line whose wipe is spent refuses further wipes until line_start_i;
      // a header that arrives while another wipe runs is not queued
      case (state_r)
        TPC_IDLE: begin
          if (hard_req && !line_used_r) begin
            // Hardware wins, software stays pending
            state_r     <= TPC_WIPE;
            kind_r      <= TPC_HARD;
            wrow_r      <= TPC_ROW_FIRST;
            wcol_r      <= 6'h00;
            wext_r      <= 1'b0;
            line_used_r <= 1'b1;
          end else if (soft_pending_r && !line_used_r && !hard_req
                       && !line_start_i) begin
            state_r        <= TPC_WIPE;
            kind_r         <= TPC_SOFT;
            wrow_r         <= 5'h00;
            wcol_r         <= 6'h00;
            wext_r         <= 1'b0;
            line_used_r    <= 1'b1;
            soft_pending_r <= soft_wr;
          end
        end
        TPC_WIPE: begin
          if (wcol_r != TPC_COL_LAST) begin
            wcol_r <= wcol_r + 6'h01;
          end else begin
            wcol_r <= 6'h00;
            if (!wext_r && kind_r == TPC_HARD && wrow_r == TPC_ROW_LAST) begin
              // Basic rows done: packet-24 row, then extension row 1
              if (ext_row_placement_bit_r) begin
                wrow_r <= TPC_PKT_ROW24;
              end else begin
                wext_r <= 1'b1;
                wrow_r <= 5'h00;
              end
            end else if (!wext_r && wrow_r == TPC_PKT_ROW24
                         && kind_r == TPC_HARD) begin
              wext_r <= 1'b1;
              wrow_r <= TPC_ROW_FIRST;
            end else if (!wext_r
                         && wrow_r == 5'(TPC_ROWS - 1)) begin
              wext_r <= 1'b1;
              wrow_r <= 5'h00;
            end else if (wext_r && wrow_r == 5'h00
                         && kind_r == TPC_HARD) begin
              wrow_r <= TPC_ROW_FIRST;
            end else begin
              wrow_r <= wrow_r + 5'h01;
            end
          end
          if (wipe_done) begin
            state_r <= TPC_IDLE;
            if (kind_r == TPC_SOFT && !soft_wr && !soft_pending_r) begin
              wipe_in_progress_flag_r <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= TPC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Data-service row counter
  // ---------------------------------------------------------------------------
  // Row advances after the last-column byte of a captured packet
  always_comb begin
    ds_row_nxt = ds_row_r;
    if (ds_hit && pkt_col_i == TPC_COL_LAST && pkt_byte_valid_i) begin
      ds_row_nxt = (ds_row_r == 5'(TPC_DS_ROWS - 1))
                   ? 5'h00 : ds_row_r + 5'h01;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ds_row_r <= 5'h00;
    end else if (!data_service_enable_bit_r) begin
      ds_row_r <= 5'h00;
    end else if (wipe_done && kind_r == TPC_SOFT) begin
      ds_row_r <= 5'h00;
    end else begin
      ds_row_r <= ds_row_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Memory write port: wipe has priority; capture bytes stored raw
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mem_wr_o     <= '0;
      ds_capture_o <= 1'b0;
    end else begin
      ds_capture_o <= ds_hit;
      // A capture byte that meets a running wipe is lost
      if (state_r == TPC_WIPE) begin
        mem_wr_o.we   <= 1'b1;
        mem_wr_o.ext  <= wext_r;
        mem_wr_o.row  <= wrow_r;
        mem_wr_o.col  <= wcol_r;
        mem_wr_o.data <= TPC_SPACE;
      end else if (ds_hit && pkt_byte_valid_i) begin
        mem_wr_o.we   <= 1'b1;
        mem_wr_o.ext  <= 1'b0;
        mem_wr_o.row  <= ds_row_r;
        mem_wr_o.col  <= pkt_col_i;
        mem_wr_o.data <= pkt_byte_i;
      end else begin
        mem_wr_o.we   <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Avalon-MM slave: reads take one wait state, writes none
  // ---------------------------------------------------------------------------
  // Read data is registered, so a read is held off for one cycle until the
  // word stands on avs_readdata_o; writes land at the edge they are seen.
  logic rd_ack_r;

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= avs_read_i && !rd_ack_r;
    end
  end

  assign avs_waitrequest_o = avs_read_i && !rd_ack_r;

  // Read data is captured once per read, in its wait-state cycle
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata_o <= TPC_UNMAPPED;
    end else if (avs_read_i && !rd_ack_r) begin
      if (avs_address_i == TPC_ADDR_CTRL) begin
        avs_readdata_o <= {28'h0, 1'b0, data_service_enable_bit_r,
                           all_lines_acquire_bit_r, ext_row_placement_bit_r};
      end else if (avs_address_i == TPC_ADDR_STATUS) begin
        avs_readdata_o <= {28'h0, low_rate_system_flag_r,
                           wipe_in_progress_flag_r,
                           service_packet_seen_flag_r,
                           link_packet_seen_flag_r};
      end else if (avs_address_i == TPC_ADDR_CHAN) begin
        avs_readdata_o <= {28'h0, ds_channel_r};
      end else if (avs_address_i == TPC_ADDR_ROW) begin
        avs_readdata_o <= {27'h0, ds_row_r};
      end else begin
        avs_readdata_o <= TPC_UNMAPPED;
      end
    end
  end

endmodule : tpc_top

`default_nettype wire

// ==== tpc_pkg.sv ====
// Package: constants and types for the teletext page wipe and data capture block
package tpc_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] TPC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] TPC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] TPC_ADDR_CHAN   = 4'h8;
  localparam logic [3:0] TPC_ADDR_ROW    = 4'hC;

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int TPC_CTRL_EXT_POS   = 0;
  localparam int TPC_CTRL_ALL_LINES = 1;
  localparam int TPC_CTRL_DS_EN     = 2;
  localparam int TPC_CTRL_WIPE_REQ  = 3;

  // ---------------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------------
  localparam int TPC_STAT_LINK      = 0;
  localparam int TPC_STAT_SERVICE   = 1;
  localparam int TPC_STAT_WIPING    = 2;
  localparam int TPC_STAT_LOW_RATE  = 3;

  // ---------------------------------------------------------------------------
  // Memory geometry and packet codes
  // ---------------------------------------------------------------------------
  localparam int          TPC_COLS       = 40;
  localparam int          TPC_ROWS       = 26;
  localparam int          TPC_DS_ROWS    = 24;
  localparam logic [7:0]  TPC_SPACE      = 8'h20;
  localparam logic [4:0]  TPC_PKT_LINK   = 5'h1B;
  localparam logic [4:0]  TPC_PKT_SVC    = 5'h1E;
  localparam logic [4:0]  TPC_PKT_DS_LO  = 5'h1E;
  localparam logic [4:0]  TPC_PKT_ROW24  = 5'h18;
  localparam logic [2:0]  TPC_MAG_SVC_HI = 3'h0;
  localparam logic [3:0]  TPC_DESIG_ZERO = 4'h0;
  localparam logic [4:0]  TPC_ROW_FIRST  = 5'h01;
  localparam logic [4:0]  TPC_ROW_LAST   = 5'h17;
  localparam logic [5:0]  TPC_COL_LAST   = 6'h27;
  localparam logic [31:0] TPC_UNMAPPED   = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Packet descriptor from the slicer and recogniser
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] mag;
    logic [4:0] pkt;
    logic [3:0] desig;
    logic       tab;
    logic       header;
    logic       first_hdr;
    logic       erase;
  } tpc_pkt_t;

  // Page memory write port
  typedef struct packed {
    logic       we;
    logic       ext;
    logic [4:0] row;
    logic [5:0] col;
    logic [7:0] data;
  } tpc_mem_wr_t;

  typedef enum logic [1:0] {
    TPC_SOFT,
    TPC_HARD
  } tpc_wipe_kind_t;

  typedef enum logic [1:0] {
    TPC_IDLE,
    TPC_WIPE
  } tpc_state_t;

endpackage : tpc_pkg

// ==== tpc_top_monitor.sv ====
// Port-level checker of the teletext page wipe and capture block
`timescale 1ns/1ps
`default_nettype none
module tpc_top_monitor
  import tpc_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        avs_waitrequest_o,
  // Packet side
  input wire logic        pkt_valid_i,
  input wire logic [7:0]  pkt_byte_i,
  input wire logic [5:0]  pkt_col_i,
  input wire logic        pkt_byte_valid_i,
  input wire logic        vbi_i,
  // Outputs watched
  input wire tpc_mem_wr_t mem_wr_o,
  input wire logic        accept_line_o,
  input wire logic        ds_capture_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_no_wait;
    avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("waitrequest held for more than one cycle");

  property p_accept;
    vbi_i |-> accept_line_o;
  endproperty
  a_accept: assert property (p_accept)
    else $error("blanking line not accepted");

  property p_cap_data;
    mem_wr_o.we && mem_wr_o.data != TPC_SPACE |-> $past(pkt_byte_valid_i)
      && mem_wr_o.data == $past(pkt_byte_i) && mem_wr_o.col == $past(pkt_col_i);
  endproperty
  a_cap_data: assert property (p_cap_data)
    else $error("captured byte differs from input byte");

  property p_cap_row;
    mem_wr_o.we && mem_wr_o.data != TPC_SPACE |-> !mem_wr_o.ext
      && mem_wr_o.row < 5'h18;
  endproperty
  a_cap_row: assert property (p_cap_row)
    else $error("capture outside basic rows 0 to 23");

  property p_col;
    mem_wr_o.we |-> mem_wr_o.col <= TPC_COL_LAST;
  endproperty
  a_col: assert property (p_col)
    else $error("write beyond last column");

  property p_rows;
    mem_wr_o.we |-> mem_wr_o.row < 5'h1A;
  endproperty
  a_rows: assert property (p_rows)
    else $error("write beyond last row");

  property p_rst_wipe;
    $rose(rst_n_i) |-> ##[1:8] (mem_wr_o.we && mem_wr_o.data == TPC_SPACE);
  endproperty
  a_rst_wipe: assert property (p_rst_wipe)
    else $error("no wipe after reset");

  property p_ds_pulse;
    ds_capture_o |-> $past(pkt_valid_i) || $past(pkt_valid_i, 2);
  endproperty
  a_ds_pulse: assert property (p_ds_pulse)
    else $error("capture pulse without packet");
endmodule : tpc_top_monitor

bind tpc_top tpc_top_monitor tpc_top_monitor_inst (.clock_i, .rst_n_i,
  .avs_waitrequest_o, .pkt_valid_i, .pkt_byte_i, .pkt_col_i,
  .pkt_byte_valid_i, .vbi_i, .mem_wr_o, .accept_line_o, .ds_capture_o);
`default_nettype wire

// ==== tpc_slicer_model.sv ====
// Behavioural slicer and packet recogniser feeding the block
`timescale 1ns/1ps
`default_nettype none
module tpc_slicer_model
  import tpc_pkg::*;
#(
  parameter int LINE = 4000
) (
  // Clock
  input  wire logic  clock_i,
  // Line timing
  output logic       line_start_o,
  // Packets
  output logic       pkt_valid_o,
  output tpc_pkt_t   pkt_o,
  output logic [7:0] pkt_byte_o,
  output logic [5:0] pkt_col_o,
  output logic       pkt_byte_valid_o
);
  int cnt = 0;

  initial begin
    line_start_o = 1'b0;
    pkt_valid_o = 1'b0;
    pkt_o = '0;
    pkt_byte_o = 8'h00;
    pkt_col_o = 6'h00;
    pkt_byte_valid_o = 1'b0;
  end

  // Free-running TV line timing
  always @(posedge clock_i) begin
    cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
    line_start_o <= (cnt == LINE - 1);
  end

  task automatic wait_line();
    @(posedge line_start_o);
    @(posedge clock_i);
  endtask : wait_line

  // Descriptor held for all bytes; on release descriptor and byte lines show inverted values, column holds
  task automatic send(input tpc_pkt_t d, input int nb);
    pkt_valid_o <= 1'b1;
    pkt_o <= d;
    for (int i = 0; i < nb; i++) begin
      @(posedge clock_i);
      pkt_byte_o <= 8'h40 + 8'(i);
      pkt_col_o <= 6'(i);
      pkt_byte_valid_o <= 1'b1;
    end
    @(posedge clock_i);
    pkt_valid_o <= 1'b0;
    pkt_byte_valid_o <= 1'b0;
    pkt_o <= ~d;
    pkt_byte_o <= ~pkt_byte_o;
    @(posedge clock_i);
  endtask : send
endmodule : tpc_slicer_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench of the teletext page wipe and capture block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpc_pkg::*;
  logic        clock_i, rst_n_i, avs_read_i, avs_write_i, vbi_i;
  logic        low_rate_det_i, avs_waitrequest_o, pkt_valid_i;
  logic        pkt_byte_valid_i, line_start_i, accept_line_o, ds_capture_o;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rv;
  logic [7:0]  pkt_byte_i;
  logic [5:0]  pkt_col_i;
  tpc_pkt_t    pkt_i;
  tpc_mem_wr_t mem_wr_o, last;
  logic [7:0]  c0 = 8'hFF; // last captured byte written to column 0
  int error_cnt = 0, n_compared = 0, n_sp = 0, n_cap = 0, n_b24 = 0;
  int n_e0 = 0, b0, b1, b2;

  tpc_top tpc_top_inst (.clock_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .pkt_valid_i, .pkt_i, .pkt_byte_i, .pkt_col_i,
    .pkt_byte_valid_i, .line_start_i, .vbi_i, .low_rate_det_i, .mem_wr_o,
    .accept_line_o, .ds_capture_o);
  tpc_slicer_model #(.LINE(4000)) tpc_slicer_model_inst (.clock_i,
    .line_start_o(line_start_i), .pkt_valid_o(pkt_valid_i), .pkt_o(pkt_i),
    .pkt_byte_o(pkt_byte_i), .pkt_col_o(pkt_col_i),
    .pkt_byte_valid_o(pkt_byte_valid_i));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Memory write tally: spaces, placement rows and captured bytes
  always @(posedge clock_i) begin
    if (mem_wr_o.we === 1'b1 && mem_wr_o.data === TPC_SPACE) begin
      n_sp <= n_sp + 1;
      if (!mem_wr_o.ext && mem_wr_o.row == 5'h18) n_b24 <= n_b24 + 1;
      if (mem_wr_o.ext && mem_wr_o.row == 5'h00) n_e0 <= n_e0 + 1;
    end else if (mem_wr_o.we === 1'b1) begin
      n_cap <= n_cap + 1;
      last <= mem_wr_o;
      if (mem_wr_o.col == 6'h00) c0 <= mem_wr_o.data;
    end
  end

  task automatic stop_test();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
    avs_write_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  // Read data is taken at the edge where waitrequest is sampled low
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
    rv = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge clock_i);
    chk(rv, e);
  endtask : rc

  task automatic s(input logic [11:0] m, input logic [3:0] f, input int n);
    tpc_slicer_model_inst.send({m, f}, n);
  endtask : s

  task automatic fl(input logic lr, input logic [11:0] m, input logic t,
                    input logic [31:0] e);
    low_rate_det_i <= lr;
    @(posedge clock_i);
    s(m, {t, 3'b000}, 0);
    rc(TPC_ADDR_STATUS, e);
    wr(TPC_ADDR_STATUS, 32'h0);
  endtask : fl

  initial begin
    repeat (80000) @(posedge clock_i);
    error_cnt++;
    stop_test();
  end

  initial begin
    rst_n_i = 1'b0;
    {avs_read_i, avs_write_i, low_rate_det_i} = 3'b000;
    vbi_i = 1'b1;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rc(TPC_ADDR_STATUS, 32'h4);
    repeat (2200) @(posedge clock_i);
    chk(n_sp, 2080);
    rc(TPC_ADDR_STATUS, 32'h0);
    rc(TPC_ADDR_CTRL, 32'h0);
    rc(4'h2, TPC_UNMAPPED);
    fl(0, {3'h1, TPC_PKT_LINK, 4'h0}, 0, 32'h1);
    fl(0, {3'h1, TPC_PKT_LINK, 4'h1}, 0, 32'h0);
    fl(1, {3'h1, TPC_PKT_LINK, 4'h0}, 1, 32'h8);
    fl(1, {3'h1, TPC_PKT_LINK, 4'h0}, 0, 32'h9);
    fl(0, {TPC_MAG_SVC_HI, TPC_PKT_SVC, 4'h0}, 0, 32'h2);
    fl(0, {3'h1, TPC_PKT_SVC, 4'h0}, 0, 32'h0);
    fl(1, {TPC_MAG_SVC_HI, TPC_PKT_SVC, 4'h0}, 0, 32'hA);
    low_rate_det_i <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      wr(TPC_ADDR_CTRL, 32'(k));
      tpc_slicer_model_inst.wait_line();
      {b0, b1, b2} = {n_sp, n_b24, n_e0};
      s(12'h0, (k == 1) ? 4'h6 : 4'h5, 0);
      tpc_slicer_model_inst.wait_line();
      chk(n_sp - b0, 1000);
      chk(n_b24 - b1, 40 * k);
      chk(n_e0 - b2, 40 - 40 * k);
    end
    tpc_slicer_model_inst.wait_line();
    b0 = n_sp;
    s(12'h0, 4'h5, 0);
    wr(TPC_ADDR_CTRL, 32'h8);
    rc(TPC_ADDR_STATUS, 32'h4);
    rc(TPC_ADDR_CTRL, 32'h0);
    tpc_slicer_model_inst.wait_line();
    chk(n_sp - b0, 1000);
    tpc_slicer_model_inst.wait_line();
    chk(n_sp - b0, 3080);
    rc(TPC_ADDR_STATUS, 32'h0);
    vbi_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk(accept_line_o, 0);
    wr(TPC_ADDR_CTRL, 32'h2);
    chk(accept_line_o, 1);
    wr(TPC_ADDR_CHAN, 32'h5);
    wr(TPC_ADDR_CTRL, 32'h6);
    tpc_slicer_model_inst.wait_line();
    {b0, b1} = {n_sp, n_cap};
    s({3'h2, 5'h1E, 4'h0}, 4'h0, 40);
    s(12'h0, 4'h5, 0);
    s({3'h2, 5'h1F, 4'h0}, 4'h0, 40);
    tpc_slicer_model_inst.wait_line();
    chk(n_sp - b0, 0);
    chk(n_cap - b1, 40);
    chk({last.row, last.col, last.data}, {5'h0, 6'h27, 8'h67});
    chk(c0, 8'h40);
    rc(TPC_ADDR_ROW, 32'h1);
    low_rate_det_i <= 1'b1;
    repeat (23) s({3'h2, 5'h1F, 4'h0}, 4'h0, 40);
    chk(last.row, 23);
    rc(TPC_ADDR_ROW, 32'h0);
    s({3'h2, 5'h1F, 4'h0}, 4'h0, 40);
    rc(TPC_ADDR_ROW, 32'h1);
    wr(TPC_ADDR_CTRL, 32'hC);
    repeat (2) tpc_slicer_model_inst.wait_line();
    rc(TPC_ADDR_ROW, 32'h0);
    stop_test();
  end
endmodule : tb
`default_nettype wire
